// file: hw/aux_mix_pkg.sv
package aux_mix_pkg;
    // ==========================================================
    // Register indices and byte addresses
    // ==========================================================
    localparam logic [3:0] AUX2_INDEX = 4'h5;
    localparam logic [3:0] AUX3_INDEX = 4'h6;
    localparam logic [3:0] GATE_INDEX = 4'h7;
    localparam logic [11:0] AUX2_ADDR = {6'h00, AUX2_INDEX, 2'h0};
    localparam logic [11:0] AUX3_ADDR = {6'h00, AUX3_INDEX, 2'h0};
    localparam logic [11:0] GATE_ADDR = {6'h00, GATE_INDEX, 2'h0};
    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int LEFT_MUTE_BIT = 15;
    localparam int LEFT_GAIN_LSB = 8;
    localparam int RIGHT_MUTE_BIT = 7;
    localparam int RIGHT_GAIN_LSB = 0;
    localparam int GAIN_W = 5;
    localparam logic [15:0] WRITABLE_MASK = 16'h9f9f;
    localparam logic [15:0] MIX_RESET = 16'h8888;
    localparam logic [4:0] GAIN_UNITY = 5'h08;
    // Gate register bits
    localparam int GATE_PDN_BIT = 0;
    localparam int GATE_MIX_EN_BIT = 1;
    localparam int GATE_ANALOG_EN_BIT = 2;
    localparam int GATE_HELD_BIT = 3;
    localparam logic [2:0] GATE_RESET = 3'h1;
    // Gain in tenths of dB: +12.0 dB minus 1.5 dB per step
    localparam int GAIN_TOP_TENTHS = 120;
    localparam int GAIN_STEP_TENTHS = 15;
endpackage

// file: hw/aux_mix_channel.sv
`timescale 1ns/1ps
module aux_mix_channel (
    input wire logic [4:0] gain,
    input wire logic mute,
    output logic signed [9:0] level_tenths,
    output logic enabled
);
    // ==========================================================
    // Gain code to level, mute to enable
    // ==========================================================
    always_comb begin
        level_tenths = 10'(aux_mix_pkg::GAIN_TOP_TENTHS)
            - 10'(aux_mix_pkg::GAIN_STEP_TENTHS) * {5'h00, gain}; // RL3 RL4
        enabled = ~mute; // RL2
    end
endmodule

// file: hw/aux_mixer_gain_mute_registers.sv
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Mute bits 15/7, gains 12:8/4:0.
// RL2: Mute 0 mixes, mute 1 silences.
// RL3: Each gain step is 1.5 dB down.
// RL4: Code 0 +12 dB, 8 unity, 31 -34.5.
// RL5: Software writes zero to reserved bits.
// RL6: Both registers reset to 0x8888.
// RL7: Reset or power-down pin forces default.
// RL8: Global conversion power-down forces default.
// RL9: Either mixer enable bit clear forces default.
// RL10: Held registers read default, discard writes.
module aux_mixer_gain_mute_registers (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_down_pin_n,
    output logic left_aux_b_mute,
    output logic [4:0] left_aux_b_gain,
    output logic right_aux_b_mute,
    output logic [4:0] right_aux_b_gain,
    output logic left_aux_c_mute,
    output logic [4:0] left_aux_c_gain,
    output logic right_aux_c_mute,
    output logic [4:0] right_aux_c_gain,
    output logic [3:0] channel_enabled,
    output logic signed [9:0] left_aux_b_level,
    output logic mix_held
);
    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    logic pdn_meta;
    logic pdn_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdn_meta <= 1'b0;
            pdn_sync <= 1'b0;
        end else begin
            pdn_meta <= power_down_pin_n;
            pdn_sync <= pdn_meta;
        end
    end

    // ==========================================================
    // State
    // ==========================================================
    logic [15:0] aux2;
    logic [15:0] aux3;
    logic [2:0] gate;
    logic [31:0] rdata_q;
    logic ready_q;
    logic err_q;
    logic [15:0] next_aux2;
    logic [15:0] next_aux3;
    logic [2:0] next_gate;
    logic [31:0] next_rdata;
    logic next_ready;
    logic next_err;
    logic held;
    logic access;
    logic commit;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & aux_mix_pkg::WRITABLE_MASK; // RL1 RL5
    endfunction

    function automatic logic known(input logic [11:0] a);
        return a == aux_mix_pkg::AUX2_ADDR || a == aux_mix_pkg::AUX3_ADDR
            || a == aux_mix_pkg::GATE_ADDR;
    endfunction

    always_comb begin
        held = ~pdn_sync // RL7
            | gate[aux_mix_pkg::GATE_PDN_BIT] // RL8
            | ~gate[aux_mix_pkg::GATE_MIX_EN_BIT] | ~gate[aux_mix_pkg::GATE_ANALOG_EN_BIT]; // RL9
        access = psel & penable & ~ready_q;
        // Writes land on the completing edge, when pready is high
        commit = psel & penable & ready_q;
        next_aux2 = aux2;
        next_aux3 = aux3;
        next_gate = gate;
        next_rdata = rdata_q;
        next_ready = access;
        next_err = access & ~known(paddr);
        if (commit && pwrite) begin
            if (paddr == aux_mix_pkg::AUX2_ADDR) begin
                next_aux2 = merge16(aux2, pwdata, pstrb);
            end
            if (paddr == aux_mix_pkg::AUX3_ADDR) begin
                next_aux3 = merge16(aux3, pwdata, pstrb);
            end
            if (paddr == aux_mix_pkg::GATE_ADDR && pstrb[0]) begin
                next_gate = pwdata[2:0];
            end
        end
        if (held) begin
            next_aux2 = aux_mix_pkg::MIX_RESET; // RL10
            next_aux3 = aux_mix_pkg::MIX_RESET; // RL10
        end
        if (access && !pwrite) begin
            case (paddr)
                aux_mix_pkg::AUX2_ADDR: next_rdata = {16'h0000, aux2};
                aux_mix_pkg::AUX3_ADDR: next_rdata = {16'h0000, aux3};
                aux_mix_pkg::GATE_ADDR: next_rdata = {28'h0000000, held, gate};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux2 <= aux_mix_pkg::MIX_RESET; // RL6 RL7
            aux3 <= aux_mix_pkg::MIX_RESET; // RL6
            gate <= aux_mix_pkg::GATE_RESET;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            aux2 <= next_aux2;
            aux3 <= next_aux3;
            gate <= next_gate;
            rdata_q <= next_rdata;
            ready_q <= next_ready;
            err_q <= next_err;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    logic signed [9:0] lvl;
    logic [3:0] en;
    aux_mix_channel u_lb (.gain(aux2[12:8]), .mute(aux2[15]), .level_tenths(lvl),
        .enabled(en[0]));
    aux_mix_channel u_rb (.gain(aux2[4:0]), .mute(aux2[7]), .level_tenths(),
        .enabled(en[1]));
    aux_mix_channel u_lc (.gain(aux3[12:8]), .mute(aux3[15]), .level_tenths(),
        .enabled(en[2]));
    aux_mix_channel u_rc (.gain(aux3[4:0]), .mute(aux3[7]), .level_tenths(),
        .enabled(en[3]));

    logic [3:0] en_q;
    logic signed [9:0] lvl_q;
    logic held_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 4'h0;
            lvl_q <= 10'sd0;
            held_q <= 1'b1;
        end else begin
            en_q <= en; // RL2
            lvl_q <= lvl; // RL3 RL4
            held_q <= held;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign left_aux_b_mute = aux2[aux_mix_pkg::LEFT_MUTE_BIT]; // RL1
    assign left_aux_b_gain = aux2[aux_mix_pkg::LEFT_GAIN_LSB +: aux_mix_pkg::GAIN_W];
    assign right_aux_b_mute = aux2[aux_mix_pkg::RIGHT_MUTE_BIT];
    assign right_aux_b_gain = aux2[aux_mix_pkg::RIGHT_GAIN_LSB +: aux_mix_pkg::GAIN_W];
    assign left_aux_c_mute = aux3[aux_mix_pkg::LEFT_MUTE_BIT];
    assign left_aux_c_gain = aux3[aux_mix_pkg::LEFT_GAIN_LSB +: aux_mix_pkg::GAIN_W];
    assign right_aux_c_mute = aux3[aux_mix_pkg::RIGHT_MUTE_BIT];
    assign right_aux_c_gain = aux3[aux_mix_pkg::RIGHT_GAIN_LSB +: aux_mix_pkg::GAIN_W];
    assign channel_enabled = en_q;
    assign left_aux_b_level = lvl_q;
    assign mix_held = held_q;

    // ==========================================================
    // Checks
    // ==========================================================
    AST_HELD_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn) // RL10
        held |=> (aux2 == aux_mix_pkg::MIX_RESET && aux3 == aux_mix_pkg::MIX_RESET))
        else $error("Held register not at default");
    AST_PIN_LOW: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        !power_down_pin_n [*3] |=> aux2 == aux_mix_pkg::MIX_RESET)
        else $error("Power-down pin did not clear");
    AST_PDN_BIT: assert property (@(posedge pclk) disable iff (!presetn) // RL8
        gate[aux_mix_pkg::GATE_PDN_BIT] |=> aux3 == aux_mix_pkg::MIX_RESET)
        else $error("Power-down bit did not clear");
    AST_ENABLES: assert property (@(posedge pclk) disable iff (!presetn) // RL9
        !(gate[1] && gate[2]) |=> aux2 == aux_mix_pkg::MIX_RESET)
        else $error("Enable bits did not clear");
    AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        ((aux2 | aux3) & ~aux_mix_pkg::WRITABLE_MASK) == 16'h0000)
        else $error("Reserved bit set");
    AST_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        (commit && pwrite && paddr == aux_mix_pkg::AUX2_ADDR && pstrb == 4'hf && !held)
        |=> aux2 == ($past(pwdata[15:0]) & aux_mix_pkg::WRITABLE_MASK))
        else $error("Write not stored");
    AST_MUTE_EN: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        ##1 channel_enabled[0] == !$past(aux2[15]))
        else $error("Mute not reflected");
    AST_LEVEL: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        ($past(aux2[12:8]) == aux_mix_pkg::GAIN_UNITY && $past(presetn)) |-> lvl_q == 10'sd0)
        else $error("Unity level wrong");
    AST_READBACK: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        (access && !pwrite && paddr == aux_mix_pkg::AUX3_ADDR)
        |=> pready && prdata == {16'h0000, $past(aux3)})
        else $error("Read data wrong");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Signals and clock
    // ==========================================================
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, power_down_pin_n = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic [3:0] pstrb = 0, channel_enabled;
    logic pready, pslverr, ev, lbm, rbm, lcm, rcm, mix_held;
    logic [4:0] lbg, rbg, lcg, rcg;
    logic signed [9:0] left_aux_b_level;
    logic [15:0] mreg[2];
    logic [2:0] mgate;
    bit pin_low;
    int err_total = 0, checks_done = 0, seed = 32'hde66d1b3;
    always #50 pclk = ~pclk;
    aux_mixer_gain_mute_registers aux_mixer_gain_mute_registers_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_down_pin_n(power_down_pin_n), .left_aux_b_mute(lbm), .left_aux_b_gain(lbg),
        .right_aux_b_mute(rbm), .right_aux_b_gain(rbg), .left_aux_c_mute(lcm),
        .left_aux_c_gain(lcg), .right_aux_c_mute(rcm), .right_aux_c_gain(rcg),
        .channel_enabled(channel_enabled), .left_aux_b_level(left_aux_b_level),
        .mix_held(mix_held));
    // ==========================================================
    // Model and checks
    // ==========================================================
    function automatic bit held_m();
        return pin_low || mgate[0] || !mgate[1] || !mgate[2];
    endfunction
    function automatic void settle();
        if (held_m()) begin
            mreg[0] = 16'h8888;
            mreg[1] = 16'h8888;
        end
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic chk_out();
        chk({lbm, lbg, rbm, rbg, lcm, lcg, rcm, rcg}, {mreg[0][15], mreg[0][12:8],
            mreg[0][7], mreg[0][4:0], mreg[1][15], mreg[1][12:8], mreg[1][7], mreg[1][4:0]});
        chk(channel_enabled, 4'(~{mreg[1][7], mreg[1][15], mreg[0][7], mreg[0][15]}));
        chk(32'(left_aux_b_level), 32'(10'(120 - 15 * int'(mreg[0][12:8]))));
        chk(32'(mix_held), 32'(held_m()));
    endtask
    // ==========================================================
    // APB master
    // ==========================================================
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rv = prdata;
        ev = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1, a, {16'h0, d});
        if (!held_m() && a == aux_mix_pkg::AUX2_ADDR) mreg[0] = d & 16'h9f9f;
        if (!held_m() && a == aux_mix_pkg::AUX3_ADDR) mreg[1] = d & 16'h9f9f;
        if (a == aux_mix_pkg::GATE_ADDR) mgate = d[2:0];
        settle();
        chk(32'(ev), 32'h0);
    endtask
    task automatic rd(input logic [11:0] a);
        logic [31:0] e;
        logic bad;
        apb(0, a, 32'h0);
        bad = a != aux_mix_pkg::AUX2_ADDR && a != aux_mix_pkg::AUX3_ADDR
            && a != aux_mix_pkg::GATE_ADDR;
        e = (a == aux_mix_pkg::AUX2_ADDR) ? mreg[0] : (a == aux_mix_pkg::AUX3_ADDR) ? mreg[1]
            : (a == aux_mix_pkg::GATE_ADDR) ? {held_m(), mgate} : 32'h0;
        chk(rv, e);
        chk(32'(ev), 32'(bad));
    endtask
    task automatic summarize();
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        #(100 * 5000);
        err_total++;
        summarize();
    end
    initial begin
        logic [15:0] d;
        logic [2:0] gv[3] = '{3'h7, 3'h4, 3'h2};
        mreg = '{16'h8888, 16'h8888};
        mgate = 3'h1;
        repeat (12) @(posedge pclk);
        chk_out();
        presetn <= 1;
        rd(aux_mix_pkg::AUX2_ADDR);
        rd(aux_mix_pkg::AUX3_ADDR);
        rd(aux_mix_pkg::GATE_ADDR);
        wr(aux_mix_pkg::AUX2_ADDR, 16'h1234);
        wr(aux_mix_pkg::GATE_ADDR, 16'h6);
        rd(aux_mix_pkg::AUX2_ADDR);
        for (int i = 0; i < 10; i++) begin
            d = 16'($random(seed)) & 16'h9f9f;
            d[12:8] = (i == 0) ? 5'h00 : (i == 1) ? 5'h08 : (i == 2) ? 5'h1f : d[12:8];
            wr(aux_mix_pkg::AUX2_ADDR, d);
            wr(aux_mix_pkg::AUX3_ADDR, 16'($random(seed)) & 16'h9f9f);
            rd(aux_mix_pkg::AUX2_ADDR);
            rd(aux_mix_pkg::AUX3_ADDR);
            chk_out();
        end
        rd(12'h020);
        for (int k = 0; k < 3; k++) begin
            wr(aux_mix_pkg::GATE_ADDR, 16'(gv[k]));
            rd(aux_mix_pkg::AUX3_ADDR);
            wr(aux_mix_pkg::AUX2_ADDR, 16'h0101);
            wr(aux_mix_pkg::GATE_ADDR, 16'h6);
            rd(aux_mix_pkg::AUX2_ADDR);
            chk_out();
            wr(aux_mix_pkg::AUX2_ADDR, 16'h1f1f);
            wr(aux_mix_pkg::AUX3_ADDR, 16'h1717);
        end
        power_down_pin_n <= 0;
        pin_low = 1;
        settle();
        repeat (6) @(posedge pclk);
        chk_out();
        wr(aux_mix_pkg::AUX3_ADDR, 16'h0202);
        power_down_pin_n <= 1;
        pin_low = 0;
        repeat (4) @(posedge pclk);
        rd(aux_mix_pkg::AUX3_ADDR);
        wr(aux_mix_pkg::AUX2_ADDR, 16'h0303);
        presetn <= 0;
        mgate = 3'h1;
        settle();
        repeat (2) @(posedge pclk);
        chk_out();
        presetn <= 1;
        rd(aux_mix_pkg::AUX2_ADDR);
        summarize();
    end
endmodule
